// ===== test_vectored_interrupt_control.sv
// self-checking bench of the interrupt controller against a core model
module test_vectored_interrupt_control
   import vic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, rst_b, regWr, regRd, extPin, slowMode;
   logic        compareAEvent, compareBEvent, secondWrapEvent, firstWrapEvent;
   logic        instrBoundary, returnFromHandler, pcPush, pcPop, vectorLoad, coreStall, globalEnable;
   logic [7:0]  regAddr, regWdata, regRdata, rnd;
   logic [10:0] changePins, altFuncActive;
   logic [9:0]  pcIn, pcSaved, vectorAddr;
   int          failures, n_compared, seed, modelErrors, stallN, expStall, popAge;
   logic [9:0]  expQ [$];
   // each entry: sense mode, pin before, pin after, flag expected
   logic [4:0]  senseTab [5] = '{5'h1C, 5'h1B, 5'h12, 5'h15, 5'h0D};
   logic [7:0]  resetAddr [5] = '{8'h38, 8'h39, 8'h3A, 8'h3B, 8'h10};

   vic_control dut (.clk_sys, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .extPin, .changePins,
      .altFuncActive, .compareAEvent, .compareBEvent, .secondWrapEvent, .firstWrapEvent, .instrBoundary,
      .returnFromHandler, .pcIn, .pcPush, .pcPop, .pcSaved, .vectorLoad, .vectorAddr, .coreStall, .globalEnable);
   vic_core_model core (.clk_sys, .rst_b, .slowMode, .coreStall, .pcPush, .pcPop, .pcSaved, .vectorLoad,
      .vectorAddr, .instrBoundary, .returnFromHandler, .pcIn, .modelErrors);

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ----------------------------------------------------------------
   // compare and bus tasks
   // ----------------------------------------------------------------
   task automatic checkReg(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic checkVec(input string what, input logic [9:0] e, input logic [9:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic checkCount(input string what, input int e, input int g);
      n_compared++;
      if (g != e) begin
         failures++;
         $display("unexpected %s expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic readCheck(input string what, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 checkReg(what, e, regRdata);
   endtask
   task automatic pulse(input logic [3:0] which);
      @(posedge clk_sys);
      {compareAEvent, compareBEvent, secondWrapEvent, firstWrapEvent} <= which;
      @(posedge clk_sys);
      {compareAEvent, compareBEvent, secondWrapEvent, firstWrapEvent} <= 4'h0;
   endtask
   task automatic waitVectors;
      for (int k = 0; k < 3000 && expQ.size() > 0; k++) @(posedge clk_sys);
      if (expQ.size() > 0) begin
         failures++;
         $display("unexpected vectors left expected 0 seen %0d", expQ.size());
         tally_and_finish();
      end
   endtask
   // ----------------------------------------------------------------
   // monitor of entry and return sequences
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst_b === 1'b1 && vectorLoad === 1'b1) begin
         checkVec("vector", expQ.size() > 0 ? expQ.pop_front() : 10'h3FF, vectorAddr);
         checkReg("entry enable", 8'h00, {7'h00, globalEnable});
         checkReg("pc push", 8'h01, {7'h00, pcPush});
         expStall = 5;
      end
      if (pcPop === 1'b1) begin
         expStall = 3;
         popAge   = 0;
      end else popAge++;
      if (popAge == 3) checkReg("return enable", 8'h01, {7'h00, globalEnable});
      if (coreStall === 1'b1) stallN++;
      else if (stallN > 0) begin
         checkCount("stall cycles", expStall, stallN);
         stallN = 0;
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'he15e;
      {failures, n_compared, stallN, expStall, popAge} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h64};
      {rst_b, regWr, regRd, regAddr, regWdata, extPin, slowMode} = '0;
      {changePins, altFuncActive} = '0;
      {compareAEvent, compareBEvent, secondWrapEvent, firstWrapEvent} = 4'h0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) readCheck("reset value", resetAddr[i], REG_RESET);
      rnd = $random(seed);
      regWrite(PIN_EVENT_MASK_ADDR, rnd);
      readCheck("pin mask", PIN_EVENT_MASK_ADDR, rnd & PIN_MASK_VALID);
      rnd = $random(seed);
      regWrite(TIMER_EVENT_MASK_ADDR, rnd);
      readCheck("timer mask", TIMER_EVENT_MASK_ADDR, rnd & TIMER_VALID);
      regWrite(TIMER_EVENT_MASK_ADDR, 8'h00);
      regWrite(PIN_EVENT_MASK_ADDR, 8'h20);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         extPin <= senseTab[i][2];
         repeat (3) @(posedge clk_sys);
         regWrite(CORE_CONTROL_ADDR, {6'h00, senseTab[i][4:3]});
         regWrite(PIN_EVENT_FLAGS_ADDR, 8'h40);
         @(posedge clk_sys);
         extPin <= senseTab[i][1];
         repeat (3) @(posedge clk_sys);
         readCheck("sense flag", PIN_EVENT_FLAGS_ADDR, senseTab[i][0] ? 8'h40 : 8'h00);
      end
      regWrite(CORE_CONTROL_ADDR, {6'h00, SENSE_LOW});
      readCheck("level flag", PIN_EVENT_FLAGS_ADDR, 8'h00);
      regWrite(CORE_CONTROL_ADDR, {6'h00, SENSE_RISE});
      regWrite(PIN_EVENT_FLAGS_ADDR, 8'h60);
      @(posedge clk_sys);
      altFuncActive <= 11'h010;
      changePins    <= 11'h011;
      repeat (3) @(posedge clk_sys);
      readCheck("masked change", PIN_EVENT_FLAGS_ADDR, 8'h00);
      @(posedge clk_sys);
      changePins <= 11'h031;
      extPin     <= 1'b1;
      repeat (3) @(posedge clk_sys);
      readCheck("pin flags", PIN_EVENT_FLAGS_ADDR, 8'h60);
      pulse(4'hF);
      readCheck("timer flags", TIMER_EVENT_FLAGS_ADDR, 8'h66);
      regWrite(TIMER_EVENT_FLAGS_ADDR, 8'h00);
      readCheck("zero write", TIMER_EVENT_FLAGS_ADDR, 8'h66);
      regWrite(TIMER_EVENT_FLAGS_ADDR, 8'h40);
      readCheck("one write", TIMER_EVENT_FLAGS_ADDR, 8'h26);
      pulse(4'h8);
      regWrite(PIN_EVENT_MASK_ADDR, 8'h70);
      regWrite(TIMER_EVENT_MASK_ADDR, 8'h66);
      expQ = '{VEC_EXT, VEC_PCHG, VEC_CMPA, VEC_CMPB, VEC_WRAP2, VEC_WRAP1};
      regWrite(STATUS_ADDR, 8'h80);
      waitVectors();
      repeat (40) @(posedge clk_sys);
      readCheck("timer served", TIMER_EVENT_FLAGS_ADDR, 8'h00);
      readCheck("pin served", PIN_EVENT_FLAGS_ADDR, 8'h00);
      readCheck("status", STATUS_ADDR, 8'h80);
      slowMode <= 1'b1;
      regWrite(CORE_CONTROL_ADDR, {6'h00, SENSE_LOW});
      expQ.push_back(VEC_EXT);
      extPin <= 1'b0;
      waitVectors();
      extPin <= 1'b1;
      repeat (40) @(posedge clk_sys);
      readCheck("level served", PIN_EVENT_FLAGS_ADDR, 8'h00);
      checkCount("core model", 0, modelErrors);
      tally_and_finish();
   end
endmodule

// ===== vic_control.sv
// interrupt control: masks, flags, priority, entry and return sequencing
module vic_control
   import vic_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [7:0]  regRdata,
   input  wire logic        extPin,
   input  wire logic [10:0] changePins,
   input  wire logic [10:0] altFuncActive,
   input  wire logic        compareAEvent,
   input  wire logic        compareBEvent,
   input  wire logic        secondWrapEvent,
   input  wire logic        firstWrapEvent,
   input  wire logic        instrBoundary,
   input  wire logic        returnFromHandler,
   input  wire logic [9:0]  pcIn,
   output logic             pcPush,
   output logic             pcPop,
   output logic [9:0]       pcSaved,
   output logic             vectorLoad,
   output logic [9:0]       vectorAddr,
   output logic             coreStall,
   output logic             globalEnable
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0]  pinMask;
   logic [7:0]  timerMask;
   logic [1:0]  senseSel;
   logic        extFlag;
   logic        pinChangeFlag;
   logic [3:0]  timerFlags;     // {cmpa, cmpb, wrap2, wrap1}
   logic        extPrev;
   logic [10:0] pinsPrev;
   vic_state_t  state;
   logic [2:0]  cycleCnt;
   logic        oneInstr;       // set after return, forces one main instruction
   logic [9:0]  stackPc;
   logic        pendExt, pendPc, pendA, pendB, pendW2, pendW1;
   logic        anyPend;
   logic [9:0]  winVec;
   logic        take;
   logic        extEdge;
   logic        pinEvent;
   logic        clrExt, clrPc;
   logic [3:0]  clrTimer;
   logic        wrPinFlags, wrTimerFlags;

   assign wrPinFlags   = regWr && regAddr == PIN_EVENT_FLAGS_ADDR;
   assign wrTimerFlags = regWr && regAddr == TIMER_EVENT_FLAGS_ADDR;

   // ----------------------------------------------------------------
   // source detection
   // ----------------------------------------------------------------
   // pin level is read even when the pin drives as output: the caller feeds the pad value
   always_comb begin
      unique case (senseSel)
         SENSE_LOW:    extEdge = 1'b0;
         SENSE_CHANGE: extEdge = extPin != extPrev;
         SENSE_FALL:   extEdge = extPrev && !extPin;
         SENSE_RISE:   extEdge = !extPrev && extPin;
      endcase
   end

   assign pinEvent = |((changePins ^ pinsPrev) & ~altFuncActive
                       & ((pinMask[PC_HI_BIT] ? UPPER_GROUP : 11'h000)
                        | (pinMask[PC_LO_BIT] ? LOWER_GROUP : 11'h000)));

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extPrev  <= 1'b1;
         pinsPrev <= 11'h000;
      end else begin
         extPrev  <= extPin;
         pinsPrev <= changePins;
      end
   end

   // ----------------------------------------------------------------
   // pending and priority
   // ----------------------------------------------------------------
   // level mode has no latch: request follows the pin directly
   assign pendExt = pinMask[EXT_BIT] && (senseSel == SENSE_LOW ? !extPin : extFlag);
   assign pendPc  = (pinMask[PC_HI_BIT] || pinMask[PC_LO_BIT]) && pinChangeFlag;
   assign pendA   = timerMask[CMPA_BIT]  && timerFlags[3];
   assign pendB   = timerMask[CMPB_BIT]  && timerFlags[2];
   assign pendW2  = timerMask[WRAP2_BIT] && timerFlags[1];
   assign pendW1  = timerMask[WRAP1_BIT] && timerFlags[0];
   assign anyPend = pendExt | pendPc | pendA | pendB | pendW2 | pendW1;

   always_comb begin
      if (pendExt) begin
         winVec = VEC_EXT;
      end else if (pendPc) begin
         winVec = VEC_PCHG;
      end else if (pendA) begin
         winVec = VEC_CMPA;
      end else if (pendB) begin
         winVec = VEC_CMPB;
      end else if (pendW2) begin
         winVec = VEC_WRAP2;
      end else begin
         winVec = VEC_WRAP1;
      end
   end

   assign take = state == VIC_RUN && globalEnable && anyPend && instrBoundary && !oneInstr && !returnFromHandler;

   // ----------------------------------------------------------------
   // entry and return sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state    <= VIC_RUN;
         cycleCnt <= 3'h0;
      end else begin
         unique case (state)
            VIC_RUN: begin
               if (take) begin
                  state    <= VIC_ENTRY;
                  cycleCnt <= ENTRY_CYCLES - 3'h1;
               end else if (returnFromHandler && instrBoundary) begin
                  state    <= VIC_RETURN;
                  cycleCnt <= RETURN_CYCLES - 3'h1;
               end
            end
            VIC_ENTRY: begin
               if (cycleCnt == 3'h1) begin
                  state    <= VIC_JUMP;
                  cycleCnt <= JUMP_CYCLES;
               end else begin
                  cycleCnt <= cycleCnt - 3'h1;
               end
            end
            VIC_JUMP: begin
               if (cycleCnt == 3'h1) begin
                  state <= VIC_RUN;
               end
               cycleCnt <= cycleCnt - 3'h1;
            end
            VIC_RETURN: begin
               if (cycleCnt == 3'h1) begin
                  state <= VIC_RUN;
               end
               cycleCnt <= cycleCnt - 3'h1;
            end
         endcase
      end
   end

   // the status register's global enable is cleared on entry and set again in the last return cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         globalEnable <= 1'b0;
      end else if (take) begin
         globalEnable <= 1'b0;
      end else if (state == VIC_RETURN && cycleCnt == 3'h1) begin
         globalEnable <= 1'b1;
      end else if (regWr && regAddr == STATUS_ADDR) begin
         globalEnable <= regWdata[GIE_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         oneInstr <= 1'b0;
      end else if (state == VIC_RETURN && cycleCnt == 3'h1) begin
         oneInstr <= 1'b1;
      end else if (state == VIC_RUN && instrBoundary) begin
         oneInstr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // core-facing outputs, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pcPush     <= 1'b0;
         pcPop      <= 1'b0;
         pcSaved    <= 10'h000;
         stackPc    <= 10'h000;
         vectorLoad <= 1'b0;
         vectorAddr <= 10'h000;
         coreStall  <= 1'b0;
      end else begin
         pcPush     <= take;
         pcPop      <= state == VIC_RUN && returnFromHandler && instrBoundary;
         vectorLoad <= take;
         // entry stalls throughout; jump and return release the core in their last cycle
         coreStall  <= take || (state == VIC_RUN && returnFromHandler && instrBoundary)
                       || state == VIC_ENTRY
                       || (state == VIC_JUMP && cycleCnt != 3'h1)
                       || (state == VIC_RETURN && cycleCnt != 3'h1);
         if (take) begin
            vectorAddr <= winVec;
            stackPc    <= pcIn;
         end
         if (state == VIC_RUN && returnFromHandler && instrBoundary) begin
            pcSaved <= stackPc;
         end else if (take) begin
            pcSaved <= pcIn;
         end
      end
   end

   // ----------------------------------------------------------------
   // vector-entry flag clears
   // ----------------------------------------------------------------
   assign clrExt   = take && winVec == VEC_EXT;
   assign clrPc    = take && winVec == VEC_PCHG;
   assign clrTimer = {take && winVec == VEC_CMPA, take && winVec == VEC_CMPB,
                      take && winVec == VEC_WRAP2, take && winVec == VEC_WRAP1};

   // ----------------------------------------------------------------
   // mask and flag registers; a set always beats a clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pinMask   <= REG_RESET;
         timerMask <= REG_RESET;
         senseSel  <= SENSE_LOW;
      end else begin
         if (regWr && regAddr == PIN_EVENT_MASK_ADDR) begin
            pinMask <= regWdata & PIN_MASK_VALID;
         end
         if (regWr && regAddr == TIMER_EVENT_MASK_ADDR) begin
            timerMask <= regWdata & TIMER_VALID;
         end
         if (regWr && regAddr == CORE_CONTROL_ADDR) begin
            senseSel <= regWdata[1:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extFlag <= 1'b0;
      end else if (senseSel == SENSE_LOW) begin
         extFlag <= 1'b0;
      end else if (extEdge) begin
         extFlag <= 1'b1;
      end else if (clrExt || (wrPinFlags && regWdata[EXT_BIT])) begin
         extFlag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pinChangeFlag <= 1'b0;
      end else if (pinEvent) begin
         pinChangeFlag <= 1'b1;
      end else if (clrPc || (wrPinFlags && regWdata[PCF_BIT])) begin
         pinChangeFlag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         timerFlags <= 4'h0;
      end else begin
         timerFlags <= ({compareAEvent, compareBEvent, secondWrapEvent, firstWrapEvent})
                       | (timerFlags & ~clrTimer
                          & ~(wrTimerFlags ? {regWdata[CMPA_BIT], regWdata[CMPB_BIT],
                                              regWdata[WRAP2_BIT], regWdata[WRAP1_BIT]} : 4'h0));
      end
   end

   // ----------------------------------------------------------------
   // read port: data one cycle after the strobe, unmapped reads zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            PIN_EVENT_MASK_ADDR:    regRdata <= pinMask;
            PIN_EVENT_FLAGS_ADDR:   regRdata <= {1'b0, extFlag, pinChangeFlag, 5'h00};
            TIMER_EVENT_MASK_ADDR:  regRdata <= timerMask;
            TIMER_EVENT_FLAGS_ADDR: regRdata <= {1'b0, timerFlags[3], timerFlags[2], 2'h0,
                                                 timerFlags[1], timerFlags[0], 1'b0};
            CORE_CONTROL_ADDR:      regRdata <= {6'h00, senseSel};
            STATUS_ADDR:            regRdata <= {globalEnable, 7'h00};
            default:                regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   entry_clears_gie_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      take |=> !globalEnable) else $error("global enable not cleared on entry");
   return_sets_gie_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state == VIC_RUN && returnFromHandler && instrBoundary) |-> ##4 globalEnable)
      else $error("global enable not set by return");
   entry_length_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      take |=> (state == VIC_ENTRY)[*3] ##1 (state == VIC_JUMP)[*2] ##1 state == VIC_RUN)
      else $error("entry sequence length wrong");
   return_length_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state == VIC_RUN && returnFromHandler && instrBoundary) |=> (state == VIC_RETURN)[*3] ##1 state == VIC_RUN)
      else $error("return sequence length wrong");
   one_instr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(state == VIC_RETURN) |-> !take) else $error("interrupt taken right after return");
   ext_level_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      senseSel == SENSE_LOW |=> !extFlag) else $error("external flag set in level mode");
   vector_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (take && winVec == VEC_CMPA && !compareAEvent) |=> !timerFlags[3] && vectorAddr == VEC_CMPA)
      else $error("vector entry did not clear flag");
   priority_order_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (take && pendExt) |=> vectorAddr == VEC_EXT) else $error("priority order broken");
   pin_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!pinMask[PC_HI_BIT] && !pinMask[PC_LO_BIT] && !pinChangeFlag) |=> !pinChangeFlag)
      else $error("pin-change flag set with groups disabled");
   write_one_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (wrTimerFlags && regWdata[WRAP1_BIT] && !firstWrapEvent) |=> !timerFlags[0])
      else $error("write one did not clear flag");
   cov_entry_c: cover property (@(posedge clk_sys) disable iff (!rst_b) take);
   cov_return_c: cover property (@(posedge clk_sys) disable iff (!rst_b) state == VIC_RETURN);
   cov_level_c: cover property (@(posedge clk_sys) disable iff (!rst_b) take && senseSel == SENSE_LOW);
endmodule

// ===== vic_core_model.sv
// partner model of the core sequencer: instruction boundaries, handler return and pc stack
module vic_core_model
   import vic_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       slowMode,
   input  wire logic       coreStall,
   input  wire logic       pcPush,
   input  wire logic       pcPop,
   input  wire logic [9:0] pcSaved,
   input  wire logic       vectorLoad,
   input  wire logic [9:0] vectorAddr,
   output logic            instrBoundary,
   output logic            returnFromHandler,
   output logic      [9:0] pcIn,
   output int              modelErrors
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       phase;
   logic       retPending;
   logic       prevBoundary;
   int         handlerLeft;
   int         sincePop;
   logic [9:0] stack [$];
   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // slow mode stands for two-cycle instructions: a boundary only every other cycle
   assign instrBoundary     = !coreStall && (phase || !slowMode);
   assign returnFromHandler = instrBoundary && retPending;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase        <= 1'b0;
         retPending   <= 1'b0;
         prevBoundary <= 1'b0;
         pcIn         <= 10'h100;
         handlerLeft  = 0;
         sincePop     = 2;
         modelErrors  = 0;
      end else begin
         phase        <= !phase;
         prevBoundary <= instrBoundary;
         if (instrBoundary) begin
            pcIn     <= pcIn + 10'h001;
            sincePop = sincePop + 1;
            if (handlerLeft == 1) retPending <= 1'b1;
            if (handlerLeft > 0) handlerLeft = handlerLeft - 1;
         end
         if (returnFromHandler) retPending <= 1'b0;
         if (vectorLoad) begin
            pcIn        <= vectorAddr;
            handlerLeft = 3;
            // entry only after a finished instruction, and never right after a return
            if (!prevBoundary || sincePop < 2) modelErrors = modelErrors + 1;
         end
         if (pcPush) stack.push_back(pcSaved);
         if (pcPop) begin
            if (stack.size() == 0 || stack.pop_back() !== pcSaved) modelErrors = modelErrors + 1;
            pcIn     <= pcSaved;
            sincePop = 0;
         end
      end
   end
endmodule

// ===== vic_pkg.sv
// package of register offsets, field positions and timing counts for the interrupt controller
package vic_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] TIMER_EVENT_FLAGS_ADDR = 8'h38;
   localparam logic [7:0] TIMER_EVENT_MASK_ADDR  = 8'h39;
   localparam logic [7:0] PIN_EVENT_FLAGS_ADDR   = 8'h3A;
   localparam logic [7:0] PIN_EVENT_MASK_ADDR    = 8'h3B;
   localparam logic [7:0] CORE_CONTROL_ADDR      = 8'h35;
   localparam logic [7:0] STATUS_ADDR            = 8'h3F;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EXT_BIT      = 6;
   localparam int PC_HI_BIT    = 5;
   localparam int PC_LO_BIT    = 4;
   localparam int PCF_BIT      = 5;
   localparam int CMPA_BIT     = 6;
   localparam int CMPB_BIT     = 5;
   localparam int WRAP2_BIT    = 2;
   localparam int WRAP1_BIT    = 1;
   localparam int GIE_BIT      = 7;
   localparam logic [7:0] PIN_MASK_VALID   = 8'h70;
   localparam logic [7:0] PIN_FLAG_VALID   = 8'h60;
   localparam logic [7:0] TIMER_VALID      = 8'h66;
   localparam logic [7:0] REG_RESET        = 8'h00;
   // ----------------------------------------------------------------
   // sense modes, vectors, timing
   // ----------------------------------------------------------------
   localparam logic [1:0] SENSE_LOW     = 2'h0;
   localparam logic [1:0] SENSE_CHANGE  = 2'h1;
   localparam logic [1:0] SENSE_FALL    = 2'h2;
   localparam logic [1:0] SENSE_RISE    = 2'h3;
   localparam logic [9:0] VEC_EXT       = 10'h001;
   localparam logic [9:0] VEC_PCHG      = 10'h002;
   localparam logic [9:0] VEC_CMPA      = 10'h003;
   localparam logic [9:0] VEC_CMPB      = 10'h004;
   localparam logic [9:0] VEC_WRAP2     = 10'h005;
   localparam logic [9:0] VEC_WRAP1     = 10'h006;
   localparam logic [2:0] ENTRY_CYCLES  = 3'h4;
   localparam logic [2:0] RETURN_CYCLES = 3'h4;
   localparam logic [2:0] JUMP_CYCLES   = 3'h2;
   // mask of pins 10..0: {pa7,pa6,pa3,pb7..pb0}; upper group is bits 10..4
   localparam logic [10:0] UPPER_GROUP  = 11'h7F0;
   localparam logic [10:0] LOWER_GROUP  = 11'h00F;
   typedef enum logic [1:0] {VIC_RUN = 2'b00, VIC_ENTRY = 2'b01, VIC_JUMP = 2'b11, VIC_RETURN = 2'b10} vic_state_t;
endpackage
